// File: biom_pkg.sv
// Shared constants and types for the jump, step, OR and copy execution unit
package biom_pkg;

   // ------------------------------------------------------------
   // Widths and field positions
   // ------------------------------------------------------------
   localparam int PC_W        = 13;           // Program counter width
   localparam int IMM_W       = 11;           // Jump immediate width
   localparam int DATA_W      = 8;            // Data path width
   localparam int FADDR_W     = 7;            // File register address width
   localparam int PAGE_LO     = 3;            // Low page bit taken from the page latch
   localparam int PAGE_HI     = 4;            // High page bit taken from the page latch

   // ------------------------------------------------------------
   // Values after reset, destination select value and increment step
   // ------------------------------------------------------------
   localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic              ZERO_RST = 1'h0;
   localparam logic              DEST_ACC = 1'h0;  // Destination bit value selecting the accumulator
   localparam logic [DATA_W-1:0] ONE      = 8'h01; // Increment step

   // ------------------------------------------------------------
   // Operation codes presented with each instruction
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      OP_NONE                 = 3'h0,         // No operation
      OP_JUMP_ABSOLUTE        = 3'h1,         // Absolute jump
      OP_STEP_UP_SKIP_ON_ZERO = 3'h2,         // Increment file register, skip if zero
      OP_OR_LITERAL_INTO_ACC  = 3'h3,         // Accumulator OR literal
      OP_OR_ACC_WITH_FILE_REG = 3'h4,         // Accumulator OR file register
      OP_COPY_FILE_REG        = 3'h5          // Copy file register
   } biom_op_t;

   // ------------------------------------------------------------
   // Execution slot states (Gray coded)
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_RUN     = 2'h0,                      // Slot executes the presented instruction
      ST_DISCARD = 2'h1                       // Slot forced to a no-operation
   } biom_state_t;

endpackage

// File: biom_exec.sv
// Execution unit for absolute jump, increment-skip, OR and file copy
//
// How it works
// - Jump loads immediate into counter bits 10:0
// - Jump fills counter bits 12:11 from latch
// - Jump takes two instruction cycles
// - Step adds one, destination bit picks target
// - Zero step result turns next slot NOP
// - OR literal into accumulator, zero flag updated
// - OR file register, destination bit picks target
// - Copy file register to chosen destination
// - Copy updates zero flag in both modes
`timescale 1ns/1ps

module biom_exec
   import biom_pkg::*;
(
   input  wire logic               ref_clk,          // Instruction clock, 20 MHz
   input  wire logic               sys_rst,          // Synchronous reset, active high
   input  wire logic               instr_valid,      // One instruction presented this cycle
   input  wire biom_op_t           instr_op,         // Operation code
   input  wire logic [IMM_W-1:0]   instr_k,          // Jump target or literal in low bits
   input  wire logic               instr_dest,       // Destination: 0 accumulator, 1 file register
   input  wire logic [FADDR_W-1:0] instr_faddr,      // File register address
   input  wire logic [DATA_W-1:0]  file_rdata,       // File register contents at instr_faddr
   input  wire logic [DATA_W-1:0]  page_latch_high,  // Page latch register
   output logic      [PC_W-1:0]    program_counter,  // Program counter
   output logic      [DATA_W-1:0]  acc,              // Accumulator
   output logic                    zero_flag,        // Zero flag
   output logic                    file_we,          // File register write pulse
   output logic      [FADDR_W-1:0] file_waddr,       // File register write address
   output logic      [DATA_W-1:0]  file_wdata,       // File register write data
   output logic                    slot_discard      // Next slot is a forced no-operation
);

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   biom_state_t         state_r,  state_nxt;         // Slot state
   logic [PC_W-1:0]     pc_r,     pc_nxt;            // Program counter
   logic [DATA_W-1:0]   acc_r,    acc_nxt;           // Accumulator
   logic                zero_r,   zero_nxt;          // Zero flag
   logic                we_r,     we_nxt;            // File write strobe
   logic [FADDR_W-1:0]  waddr_r,  waddr_nxt;         // File write address
   logic [DATA_W-1:0]   wdata_r,  wdata_nxt;         // File write data
   logic                disc_r,   disc_nxt;          // Discard flag copy for the port
   logic                exec;                        // Instruction really executes
   logic [DATA_W-1:0]   result;                      // Arithmetic or logic result

   // Zero test of an 8-bit result, shared by every flag update
   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      return (v == '0);
   endfunction

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   // An instruction is executed only in a running slot
   assign exec = instr_valid && (state_r == ST_RUN);

   always_comb
   begin
      state_nxt = ST_RUN;
      pc_nxt    = pc_r;
      acc_nxt   = acc_r;
      zero_nxt  = zero_r;
      we_nxt    = 1'h0;
      waddr_nxt = instr_faddr;
      wdata_nxt = wdata_r;
      result    = file_rdata;
      // Every presented slot, executed or discarded, advances the counter, except an executed jump, which reloads it below
      if (instr_valid)
      begin
         pc_nxt = pc_r + 13'h0001;
      end
      if (exec)
      begin
         case (instr_op)
            OP_JUMP_ABSOLUTE:
            begin
               // Target from immediate and page bits; flags untouched
               pc_nxt    = {page_latch_high[PAGE_HI:PAGE_LO], instr_k};
               state_nxt = ST_DISCARD;
            end
            OP_STEP_UP_SKIP_ON_ZERO:
            begin
               // Increment without flag change
               result = file_rdata + ONE;
               if (is_zero(result))
               begin
                  state_nxt = ST_DISCARD;
               end
            end
            OP_OR_LITERAL_INTO_ACC:
            begin
               // Literal OR always lands in the accumulator
               result   = acc_r | instr_k[DATA_W-1:0];
               zero_nxt = is_zero(result);
            end
            OP_OR_ACC_WITH_FILE_REG:
            begin
               result   = acc_r | file_rdata;
               zero_nxt = is_zero(result);
            end
            OP_COPY_FILE_REG:
            begin
               // Write-back to itself still tests for zero
               result   = file_rdata;
               zero_nxt = is_zero(result);
            end
            default:
            begin
               result = file_rdata;
            end
         endcase
         // Destination steering for file-operand instructions
         if (instr_op == OP_STEP_UP_SKIP_ON_ZERO || instr_op == OP_OR_ACC_WITH_FILE_REG ||
             instr_op == OP_COPY_FILE_REG)
         begin
            if (instr_dest == DEST_ACC)
            begin
               acc_nxt = result;
            end
            else
            begin
               we_nxt    = 1'h1;
               wdata_nxt = result;
            end
         end
         else if (instr_op == OP_OR_LITERAL_INTO_ACC)
         begin
            acc_nxt = result;
         end
      end
      disc_nxt = (state_nxt == ST_DISCARD);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_r <= ST_RUN;
         pc_r    <= PC_RST;
         acc_r   <= ACC_RST;
         zero_r  <= ZERO_RST;
         we_r    <= 1'h0;
         waddr_r <= '0;
         wdata_r <= '0;
         disc_r  <= 1'h0;
      end
      else
      begin
         state_r <= state_nxt;
         pc_r    <= pc_nxt;
         acc_r   <= acc_nxt;
         zero_r  <= zero_nxt;
         we_r    <= we_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         disc_r  <= disc_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign program_counter = pc_r;
   assign acc             = acc_r;
   assign zero_flag       = zero_r;
   assign file_we         = we_r;
   assign file_waddr      = waddr_r;
   assign file_wdata      = wdata_r;
   assign slot_discard    = disc_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // Jump target low bits come from the immediate
   property p_jump_low;
      exec && instr_op == OP_JUMP_ABSOLUTE |=> pc_r[IMM_W-1:0] == $past(instr_k);
   endproperty
   a_jump_low: assert property (p_jump_low) else $error("jump low bits wrong");

   // Jump page bits come from the page latch, flags untouched
   property p_jump_page;
      exec && instr_op == OP_JUMP_ABSOLUTE |=>
         pc_r[PC_W-1:IMM_W] == $past(page_latch_high[PAGE_HI:PAGE_LO]) && $stable(zero_r);
   endproperty
   a_jump_page: assert property (p_jump_page) else $error("jump page bits wrong");

   // Jump consumes the following slot, then runs again
   property p_jump_two;
      exec && instr_op == OP_JUMP_ABSOLUTE |=> slot_discard ##1 state_r == ST_RUN;
   endproperty
   a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

   // Increment to accumulator leaves zero flag alone
   property p_step_acc;
      exec && instr_op == OP_STEP_UP_SKIP_ON_ZERO && instr_dest == DEST_ACC |=>
         acc_r == $past(file_rdata) + ONE && $stable(zero_r) && !file_we;
   endproperty
   a_step_acc: assert property (p_step_acc) else $error("increment result wrong");

   // Skip happens exactly when the increment wraps to zero
   property p_step_skip;
      exec && instr_op == OP_STEP_UP_SKIP_ON_ZERO |=> slot_discard == ($past(file_rdata) == 8'hFF);
   endproperty
   a_step_skip: assert property (p_step_skip) else $error("skip decision wrong");

   // Literal OR result and its zero flag
   property p_or_lit;
      exec && instr_op == OP_OR_LITERAL_INTO_ACC |=>
         acc_r == ($past(acc_r) | $past(instr_k[DATA_W-1:0])) && zero_r == (acc_r == 8'h00);
   endproperty
   a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");

   // File OR with file destination writes the register
   property p_or_file;
      exec && instr_op == OP_OR_ACC_WITH_FILE_REG && instr_dest != DEST_ACC |=>
         file_we && file_wdata == ($past(acc_r) | $past(file_rdata)) && $stable(acc_r);
   endproperty
   a_or_file: assert property (p_or_file) else $error("file OR wrong");

   // Copy to accumulator
   property p_copy_acc;
      exec && instr_op == OP_COPY_FILE_REG && instr_dest == DEST_ACC |=> acc_r == $past(file_rdata);
   endproperty
   a_copy_acc: assert property (p_copy_acc) else $error("copy to accumulator wrong");

   // Copy back to itself tests the register for zero
   property p_copy_test;
      exec && instr_op == OP_COPY_FILE_REG && instr_dest != DEST_ACC |=>
         file_we && file_waddr == $past(instr_faddr) && zero_r == ($past(file_rdata) == 8'h00);
   endproperty
   a_copy_test: assert property (p_copy_test) else $error("copy zero test wrong");

   // Zero flag follows the OR or copy result
   property p_zero;
      exec && (instr_op == OP_OR_ACC_WITH_FILE_REG || instr_op == OP_COPY_FILE_REG) |=>
         zero_r == ((file_we ? file_wdata : acc_r) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule

// File: biom_exec_bench.sv
// Self-checking bench for the jump, step, OR and copy execution unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module biom_exec_bench
   import biom_pkg::*;
;
   // ------------------------------------------------------------
   // Expected outputs after one clock edge
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [PC_W-1:0]    pc;       // Program counter
      logic [DATA_W-1:0]  acc;      // Accumulator
      logic               z;        // Zero flag
      logic               we;       // File write pulse
      logic [FADDR_W-1:0] waddr;    // File write address
      logic [DATA_W-1:0]  wdata;    // File write data
      logic               disc;     // Forced no-operation slot
   } biom_exp_t;

   // ------------------------------------------------------------
   // Stimulus, outputs and reference state
   // ------------------------------------------------------------
   logic               ref_clk         = 1'h0;     // Instruction clock
   logic               sys_rst         = 1'h1;     // Reset, held from time zero
   logic               instr_valid     = 1'h0;     // Slot presented
   biom_op_t           instr_op        = OP_NONE;  // Operation code
   logic [IMM_W-1:0]   instr_k         = 11'h000;  // Jump target or literal
   logic               instr_dest      = 1'h0;     // Destination select
   logic [FADDR_W-1:0] instr_faddr     = 7'h00;    // File address
   logic [DATA_W-1:0]  file_rdata      = 8'h00;    // File read data
   logic [DATA_W-1:0]  page_latch_high = 8'h00;    // Page latch
   wire  [PC_W-1:0]    program_counter;            // Program counter out
   wire  [DATA_W-1:0]  acc;                        // Accumulator out
   wire                zero_flag;                  // Zero flag out
   wire                file_we;                    // File write pulse out
   wire  [FADDR_W-1:0] file_waddr;                 // File write address out
   wire  [DATA_W-1:0]  file_wdata;                 // File write data out
   wire                slot_discard;               // Forced slot out
   logic [PC_W-1:0]    m_pc            = 13'h0000; // Reference counter
   logic [DATA_W-1:0]  m_acc           = 8'h00;    // Reference accumulator
   logic               m_z             = 1'h0;     // Reference zero flag
   logic               m_disc          = 1'h0;     // Reference forced slot
   biom_exp_t          exp_q[$];                   // Notes awaiting comparison
   biom_exp_t          got_e;                      // Note under comparison
   integer             seed            = 32'hE66AB6F6; // Fixed seed
   int                 n_mismatch      = 0;        // Mismatches seen
   int                 n_checks        = 0;        // Comparisons made

   // Clock, 50 ns period
   always #25 ref_clk = ~ref_clk;

   // ------------------------------------------------------------
   // Design under test
   // ------------------------------------------------------------
   biom_exec DUT
   (
      .ref_clk         (ref_clk),
      .sys_rst         (sys_rst),
      .instr_valid     (instr_valid),
      .instr_op        (instr_op),
      .instr_k         (instr_k),
      .instr_dest      (instr_dest),
      .instr_faddr     (instr_faddr),
      .file_rdata      (file_rdata),
      .page_latch_high (page_latch_high),
      .program_counter (program_counter),
      .acc             (acc),
      .zero_flag       (zero_flag),
      .file_we         (file_we),
      .file_waddr      (file_waddr),
      .file_wdata      (file_wdata),
      .slot_discard    (slot_discard)
   );

   // ------------------------------------------------------------
   // Driver: random slot at the falling edge, note the outcome
   // ------------------------------------------------------------
   task automatic drive(input logic rst);
      logic [31:0]       r;
      logic [31:0]       r2;
      logic [DATA_W-1:0] res;
      logic              has_res;
      biom_exp_t         e;
      r = $random(seed);
      r2 = $random(seed);
      has_res = 1'h0;
      res = 8'h00;
      e = '0;
      sys_rst = rst;
      instr_valid = (r[2:0] != 3'h0);
      // Codes 6 and 7 are undefined and must behave as a no-operation
      instr_op = biom_op_t'(r[5:3]);
      instr_dest = r[6];
      instr_faddr = r[13:7];
      instr_k = r[24:14];
      // Bias literal and file data toward zero results; page bits stay fully random
      if (r[25])
         instr_k[7:0] = 8'h00;
      file_rdata = r[26] ? 8'hFF : (r[27] ? 8'h00 : r2[7:0]);
      page_latch_high = r2[15:8];
      if (rst)
      begin
         m_pc = 13'h0000;
         m_acc = 8'h00;
         m_z = 1'h0;
         m_disc = 1'h0;
      end
      else if (m_disc)
      begin
         // Forced slot: instruction ignored, counter still moves when the slot is valid
         m_disc = 1'h0;
         if (instr_valid)
            m_pc = m_pc + 13'h0001;
      end
      else if (instr_valid)
      begin
         m_pc = m_pc + 13'h0001;
         case (instr_op)
            OP_JUMP_ABSOLUTE:
            begin
               m_pc = {page_latch_high[PAGE_HI:PAGE_LO], instr_k};
               m_disc = 1'h1;
            end
            OP_STEP_UP_SKIP_ON_ZERO:
            begin
               res = file_rdata + 8'h01;
               m_disc = (res == 8'h00);
               has_res = 1'h1;
            end
            OP_OR_LITERAL_INTO_ACC:
            begin
               m_acc = m_acc | instr_k[7:0];
               m_z = (m_acc == 8'h00);
            end
            OP_OR_ACC_WITH_FILE_REG:
            begin
               res = m_acc | file_rdata;
               m_z = (res == 8'h00);
               has_res = 1'h1;
            end
            OP_COPY_FILE_REG:
            begin
               res = file_rdata;
               m_z = (res == 8'h00);
               has_res = 1'h1;
            end
            default:
            begin
               // Empty or undefined codes move only the counter
            end
         endcase
      end
      // Destination bit routes the result
      if (has_res && instr_dest)
      begin
         e.we = 1'h1;
         e.waddr = instr_faddr;
         e.wdata = res;
      end
      else if (has_res)
         m_acc = res;
      e.pc = m_pc;
      e.acc = m_acc;
      e.z = m_z;
      e.disc = m_disc;
      exp_q.push_back(e);
   endtask

   // ------------------------------------------------------------
   // Monitor: compare the oldest note after each rising edge
   // ------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      #1;
      if (exp_q.size() > 0)
      begin
         got_e = exp_q.pop_front();
         `CHK("program_counter", got_e.pc, program_counter)
         `CHK("acc", got_e.acc, acc)
         `CHK("zero_flag", got_e.z, zero_flag)
         `CHK("file_we", got_e.we, file_we)
         `CHK("slot_discard", got_e.disc, slot_discard)
         // Write address and data only matter with the pulse
         if (got_e.we === 1'h1)
         begin
            `CHK("file_waddr", got_e.waddr, file_waddr)
            `CHK("file_wdata", got_e.wdata, file_wdata)
         end
      end
   end

   // Verdict and end of run
   task automatic stop_test;
      if (n_mismatch == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence: reset, random run, mid-run reset, random run
   // ------------------------------------------------------------
   initial
   begin
      repeat (3) @(negedge ref_clk) drive(1'h1);
      repeat (1500) @(negedge ref_clk) drive(1'h0);
      repeat (2) @(negedge ref_clk) drive(1'h1);
      repeat (1500) @(negedge ref_clk) drive(1'h0);
      // Bounded drain of the remaining notes
      for (int i = 0; i < 5 && exp_q.size() > 0; i++)
         @(posedge ref_clk);
      #2;
      if (exp_q.size() > 0)
         n_mismatch++;
      stop_test();
   end
endmodule
